// *** rtl/agr_pkg.sv ***
// package: register map, field layout, reset values and timing of the converter config block
package agr_pkg;

   // ----------------------------------------------------------------
   // register byte addresses and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] AGR_ADDR_GAIN     = 8'h0C;  // index 03h
   localparam logic [7:0] AGR_ADDR_RATE     = 8'h10;  // index 04h
   localparam logic [7:0] AGR_ADDR_VREF     = 8'h14;  // index 05h
   localparam logic [7:0] AGR_ADDR_CTRL     = 8'h20;  // control and status
   localparam logic [7:0] AGR_RST_GAIN      = 8'h00;
   localparam logic [7:0] AGR_RST_RATE      = 8'h14;
   localparam logic [7:0] AGR_RST_VREF      = 8'h10;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int AGR_WAIT_LSB  = 5;   // start wait code 7:5
   localparam int AGR_MODE_LSB  = 3;   // amplifier mode 4:3
   localparam int AGR_GAIN_LSB  = 0;   // gain code 2:0
   localparam int AGR_CHOP_BIT  = 7;
   localparam int AGR_CLK_BIT   = 6;
   localparam int AGR_SHOT_BIT  = 5;
   localparam int AGR_FILT_BIT  = 4;
   localparam int AGR_RATE_LSB  = 0;   // output rate 3:0
   localparam int AGR_MON_LSB   = 6;
   localparam int AGR_NBUF_BIT  = 4;
   localparam int AGR_VSEL_LSB  = 2;
   localparam int AGR_ICFG_LSB  = 0;

   // ----------------------------------------------------------------
   // codes
   // ----------------------------------------------------------------
   localparam logic [1:0] AGR_AMP_BYPASS    = 2'h0;
   localparam logic [1:0] AGR_AMP_ON        = 2'h1;
   localparam logic [1:0] AGR_VSEL_RSVD     = 2'h3;
   localparam logic [3:0] AGR_RATE_RSVD     = 4'hF;
   localparam logic [2:0] AGR_WAIT_RSVD     = 3'h6;

   // ----------------------------------------------------------------
   // timing: one modulator period in system clocks
   // ----------------------------------------------------------------
   localparam int AGR_CLK_HZ        = 10_000_000;
   localparam int AGR_MOD_PERIOD_NS = 3906;   // modulator period, nominal
   localparam int AGR_MOD_CYC       =
      (AGR_MOD_PERIOD_NS * (AGR_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int AGR_CNT_W         = 16;

   // decoded configuration handed to the converter core
   typedef struct packed {
      logic       amp_enable;   // amplifier active
      logic [7:0] gain_factor;  // one-hot power of two
      logic       chop_en;
      logic       ext_clk_sel;
      logic       single_shot;
      logic       low_lat_filter;
      logic [3:0] output_rate_sel;
      logic [1:0] vr_monitor_cfg;
      logic       neg_vr_buffer_bypass;
      logic [1:0] vr_input_select;
      logic [1:0] internal_vr_config;
   } agr_cfg_s;

endpackage

// *** rtl/agr_config.sv ***
// module: apb register block with start-wait timer for the converter configuration
//
// Our own choice: the APB register port.

// Operation
// - wait code 7:5 gives start wait in modulator periods
// - wait applies only to first conversion after a restarting write
// - mode 00 bypasses amplifier, 01 enables it, 10 and 11 reserved
// - gain code 2:0 gives gain as power of two
// - gain register at 03h, reset 00h
// - data rate bit 7 enables global chop, default off
// - data rate bit 6 selects external clock, default internal
// - data rate bit 5 selects single-shot, default continuous
// - data rate bit 4 selects low-latency filter, default, else sinc3
// - output rate code 3:0 sets samples per second, 1111 reserved
// - data rate register at 04h, reset 14h
// - reference register at 05h, reset 10h, four fields
// - reference select 00 pair0, 01 pair1, 10 internal, 11 reserved
module agr_config
   import agr_pkg::*;
(
   input  wire logic             clk,          // 10 MHz system clock
   input  wire logic             rst,          // async reset, active high
   input  wire logic             psel,         // apb select
   input  wire logic             penable,      // apb access phase
   input  wire logic             pwrite,       // apb direction
   input  wire logic [7:0]       paddr,        // apb byte address
   input  wire logic [31:0]      pwdata,       // apb write data
   output logic                  pready,       // apb ready
   output logic [31:0]           prdata,       // apb read data
   output logic                  pslverr,      // apb error
   output agr_pkg::agr_cfg_s     cfg,          // decoded configuration
   output logic                  conv_start,   // pulse: first conversion may start
   output logic                  wait_busy     // start wait running
);
   import agr_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      AGR_IDLE = 2'b01,
      AGR_WAIT = 2'b10
   } agr_state_e;

   logic [7:0]            gain_reg;
   logic [7:0]            rate_reg;
   logic [7:0]            vref_reg;
   logic                  restart;       // write that resets the filter
   logic                  rsvd_seen;     // sticky: reserved code written
   agr_state_e            state;
   logic [AGR_CNT_W-1:0]  period_cnt;    // modulator periods left
   logic [AGR_CNT_W-1:0]  tick_cnt;      // clocks within one period
   logic [AGR_CNT_W-1:0]  next_wait;
   logic                  wr_en;
   logic                  rd_en;
   logic                  addr_ok;
   logic [31:0]           next_rdata;
   logic                  rsvd_wr;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // zero wait states: every access completes in its first access cycle
   assign wr_en   = psel && penable && pwrite && pready;
   assign rd_en   = psel && penable && !pwrite && pready;
   assign addr_ok = (paddr == AGR_ADDR_GAIN) || (paddr == AGR_ADDR_RATE) ||
                    (paddr == AGR_ADDR_VREF) || (paddr == AGR_ADDR_CTRL);

   // ready raised in setup, so the access phase lasts one cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // error flag for unmapped addresses, meaningful with pready
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // gain register storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gain_reg <= AGR_RST_GAIN;
      end else if (wr_en && paddr == AGR_ADDR_GAIN) begin
         gain_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rate_reg <= AGR_RST_RATE;
      end else if (wr_en && paddr == AGR_ADDR_RATE) begin
         rate_reg <= pwdata[7:0];
      end
   end

   // reference register storage, bit 5 kept as written
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vref_reg <= AGR_RST_VREF;
      end else if (wr_en && paddr == AGR_ADDR_VREF) begin
         vref_reg <= pwdata[7:0];
      end
   end

   // reserved codes flagged, device does not defend against them
   always_comb begin
      rsvd_wr = 1'b0;
      if (wr_en && paddr == AGR_ADDR_GAIN) begin
         rsvd_wr = (pwdata[AGR_MODE_LSB+1] == 1'b1) ||
                   (pwdata[AGR_WAIT_LSB+:3] == AGR_WAIT_RSVD);
      end else if (wr_en && paddr == AGR_ADDR_RATE) begin
         rsvd_wr = (pwdata[AGR_RATE_LSB+:4] == AGR_RATE_RSVD);
      end else if (wr_en && paddr == AGR_ADDR_VREF) begin
         rsvd_wr = (pwdata[AGR_VSEL_LSB+:2] == AGR_VSEL_RSVD) ||
                   (pwdata[AGR_ICFG_LSB+:2] == 2'h3);
      end
   end

   // sticky flag, set wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsvd_seen <= 1'b0;
      end else if (rsvd_wr) begin
         rsvd_seen <= 1'b1;
      end else if (wr_en && paddr == AGR_ADDR_CTRL && pwdata[0]) begin
         rsvd_seen <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         AGR_ADDR_GAIN: next_rdata[7:0] = gain_reg;
         AGR_ADDR_RATE: next_rdata[7:0] = rate_reg;
         AGR_ADDR_VREF: next_rdata[7:0] = vref_reg;
         AGR_ADDR_CTRL: next_rdata[1:0] = {wait_busy, rsvd_seen};
         default:       next_rdata = 32'h0000_0000;
      endcase
   end

   // read data latched in setup so it stands through the access cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // decoded configuration outputs
   // ----------------------------------------------------------------
   // mode 01 powers the amplifier; bypass and reserved keep it off
   // gain one-hot from code; relies on gain 000 in bypass
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg <= '0;
         cfg.low_lat_filter       <= AGR_RST_RATE[AGR_FILT_BIT];
         cfg.output_rate_sel      <= AGR_RST_RATE[AGR_RATE_LSB+:4];
         cfg.neg_vr_buffer_bypass <= AGR_RST_VREF[AGR_NBUF_BIT];
         cfg.gain_factor          <= 8'h01;
      end else begin
         cfg.amp_enable           <= gain_reg[AGR_MODE_LSB+:2] == AGR_AMP_ON;
         cfg.gain_factor          <= 8'h01 << gain_reg[AGR_GAIN_LSB+:3];
         cfg.chop_en              <= rate_reg[AGR_CHOP_BIT];
         cfg.ext_clk_sel          <= rate_reg[AGR_CLK_BIT];
         cfg.single_shot          <= rate_reg[AGR_SHOT_BIT];
         cfg.low_lat_filter       <= rate_reg[AGR_FILT_BIT];
         cfg.output_rate_sel      <= rate_reg[AGR_RATE_LSB+:4];
         cfg.vr_monitor_cfg       <= vref_reg[AGR_MON_LSB+:2];
         cfg.neg_vr_buffer_bypass <= vref_reg[AGR_NBUF_BIT];
         cfg.vr_input_select      <= vref_reg[AGR_VSEL_LSB+:2];
         cfg.internal_vr_config   <= vref_reg[AGR_ICFG_LSB+:2];
      end
   end

   // ----------------------------------------------------------------
   // start wait timer
   // ----------------------------------------------------------------
   // only a write that changes a stored value restarts the filter
   assign restart = wr_en && (
      (paddr == AGR_ADDR_GAIN && pwdata[7:0] != gain_reg) ||
      (paddr == AGR_ADDR_RATE && pwdata[7:0] != rate_reg) ||
      (paddr == AGR_ADDR_VREF && pwdata[7:0] != vref_reg));

   // wait length from the code in the new gain value, else from the code in gain_reg
   always_comb begin
      next_wait = 16'd14;
      case ((paddr == AGR_ADDR_GAIN) ? pwdata[7:5] : gain_reg[7:5])
         3'h0:    next_wait = 16'd14;
         3'h1:    next_wait = 16'd25;
         3'h2:    next_wait = 16'd64;
         3'h3:    next_wait = 16'd256;
         3'h4:    next_wait = 16'd1024;
         3'h5:    next_wait = 16'd2048;
         3'h7:    next_wait = 16'd1;
         default: next_wait = 16'd14;
      endcase
   end

   // counts modulator periods, a new restart reloads the wait
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state      <= AGR_IDLE;
         period_cnt <= '0;
         tick_cnt   <= '0;
      end else if (restart) begin
         state      <= AGR_WAIT;
         period_cnt <= next_wait;
         tick_cnt   <= AGR_CNT_W'(AGR_MOD_CYC - 1);
      end else begin
         case (state)
            AGR_WAIT: begin
               if (tick_cnt != '0) begin
                  tick_cnt <= tick_cnt - 1'b1;
               end else if (period_cnt == 16'd1) begin
                  state      <= AGR_IDLE;
                  period_cnt <= '0;
               end else begin
                  period_cnt <= period_cnt - 1'b1;
                  tick_cnt   <= AGR_CNT_W'(AGR_MOD_CYC - 1);
               end
            end
            default: state <= AGR_IDLE;
         endcase
      end
   end

   // start pulse and busy level registered from the timer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_start <= 1'b0;
         wait_busy  <= 1'b0;
      end else begin
         conv_start <= !restart && state == AGR_WAIT && tick_cnt == '0 &&
                       period_cnt == 16'd1;
         wait_busy  <= restart || (state == AGR_WAIT && !(tick_cnt == '0 &&
                       period_cnt == 16'd1));
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_gain_write(logic [7:0] v);
      wr_en && paddr == AGR_ADDR_GAIN && pwdata[7:0] == v;
   endsequence

   a_gain_reset_value: assert property (@(posedge clk)
      $rose(!rst) |-> gain_reg == AGR_RST_GAIN)
      else $error("gain register reset value wrong");

   a_rate_reset_value: assert property (@(posedge clk)
      $rose(!rst) |-> rate_reg == AGR_RST_RATE)
      else $error("rate register reset value wrong");

   a_vref_reset_value: assert property (@(posedge clk)
      $rose(!rst) |-> vref_reg == AGR_RST_VREF)
      else $error("reference register reset value wrong");

   // a later restart reloads the wait, so it may end this attempt instead
   a_min_wait_one: assert property (@(posedge clk) disable iff (rst)
      (restart && next_wait == 16'd1) |-> ##1 wait_busy [*2] ##[1:80] (conv_start || restart))
      else $error("one period wait did not end in time");

   a_no_start_idle: assert property (@(posedge clk) disable iff (rst)
      (state == AGR_IDLE && !restart) |=> !conv_start)
      else $error("start pulse without restarting write");

   a_amp_mode: assert property (@(posedge clk) disable iff (rst)
      s_gain_write(8'h08) ##1 !(wr_en && paddr == AGR_ADDR_GAIN) |=> cfg.amp_enable)
      else $error("amplifier not enabled by mode 01");

   a_gain_onehot: assert property (@(posedge clk) disable iff (rst)
      ##1 cfg.gain_factor == (8'h01 << $past(gain_reg[2:0])))
      else $error("gain factor does not follow code");

   a_chop_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 cfg.chop_en == $past(rate_reg[AGR_CHOP_BIT]))
      else $error("chop enable does not follow register");

   a_shot_clk: assert property (@(posedge clk) disable iff (rst)
      ##1 {cfg.ext_clk_sel, cfg.single_shot} == $past(rate_reg[6:5]))
      else $error("mode or clock select does not follow register");

   a_vsel_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 cfg.vr_input_select == $past(vref_reg[3:2]))
      else $error("reference select does not follow register");

   a_clk_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 cfg.ext_clk_sel == $past(rate_reg[AGR_CLK_BIT]))
      else $error("clock select does not follow register");

   a_filter_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 cfg.low_lat_filter == $past(rate_reg[AGR_FILT_BIT]))
      else $error("filter select does not follow register");

   a_rate_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 cfg.output_rate_sel == $past(rate_reg[3:0]))
      else $error("output rate does not follow register");

   a_vref_monitor: assert property (@(posedge clk) disable iff (rst)
      ##1 {cfg.vr_monitor_cfg, cfg.neg_vr_buffer_bypass} == $past({vref_reg[7:6], vref_reg[4]}))
      else $error("monitor or buffer bypass does not follow register");

   a_vref_internal: assert property (@(posedge clk) disable iff (rst)
      ##1 cfg.internal_vr_config == $past(vref_reg[1:0]))
      else $error("internal reference config does not follow register");

   a_cfg_reset_value: assert property (@(posedge clk)
      $rose(!rst) |-> cfg.low_lat_filter && cfg.output_rate_sel == AGR_RST_RATE[3:0])
      else $error("decoded rate fields wrong after reset");

   a_bypass_amp_off: assert property (@(posedge clk) disable iff (rst)
      gain_reg[AGR_MODE_LSB+:2] != AGR_AMP_ON |=> !cfg.amp_enable)
      else $error("amplifier on outside mode 01");

   a_restart_busy: assert property (@(posedge clk) disable iff (rst)
      restart |=> wait_busy)
      else $error("restarting write did not start the wait");

   a_busy_needs_restart: assert property (@(posedge clk) disable iff (rst)
      (!wait_busy && !restart) |=> !wait_busy)
      else $error("wait began without a restarting write");

   a_start_one_cycle: assert property (@(posedge clk) disable iff (rst)
      conv_start |=> !conv_start)
      else $error("start pulse longer than one cycle");

   a_read_upper_zero: assert property (@(posedge clk) disable iff (rst)
      rd_en |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");

endmodule

// *** bench/agr_config_tb.sv ***
// testbench: apb register access, decoded configuration and start wait of the config block
module agr_config_tb
   import agr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, conv_start, wait_busy;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   agr_cfg_s    cfg;
   int          n_errors, comparisons;
   logic [7:0]  sh_gain, sh_rate, sh_vref;   // shadow of what software wrote

   agr_config DUT (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .cfg(cfg), .conv_start(conv_start), .wait_busy(wait_busy)
   );

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // one apb transfer; upper write bits are junk since the block ignores them
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
      logic [23:0] junk;
      junk = 24'($urandom);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {junk, d};
      @(posedge clk);
      penable <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
      check("write error flag", {31'h0, err}, 32'h0);
      if (a == AGR_ADDR_GAIN) sh_gain = d;
      if (a == AGR_ADDR_RATE) sh_rate = d;
      if (a == AGR_ADDR_VREF) sh_vref = d;
   endtask

   function automatic agr_cfg_s exp_cfg(input logic [7:0] g, input logic [7:0] r,
                                        input logic [7:0] v);
      agr_cfg_s c;
      c.amp_enable = (g[4:3] == 2'b01);
      c.gain_factor = 8'h01 << g[2:0];
      c.chop_en = r[7];
      c.ext_clk_sel = r[6];
      c.single_shot = r[5];
      c.low_lat_filter = r[4];
      c.output_rate_sel = r[3:0];
      c.vr_monitor_cfg = v[7:6];
      c.neg_vr_buffer_bypass = v[4];
      c.vr_input_select = v[3:2];
      c.internal_vr_config = v[1:0];
      return c;
   endfunction

   function automatic int wait_len(input logic [2:0] code);
      case (code)
         3'h0: return 14;
         3'h1: return 25;
         3'h2: return 64;
         3'h3: return 256;
         3'h4: return 1024;
         3'h5: return 2048;
         3'h7: return 1;
         default: return 14;
      endcase
   endfunction

   // readback of all three registers plus the decoded outputs
   task automatic check_all();
      logic [31:0] rd;
      logic err;
      agr_cfg_s ec;
      apb(1'b0, AGR_ADDR_GAIN, 8'h00, rd, err);
      check("gain reg", rd, {24'h0, sh_gain});
      apb(1'b0, AGR_ADDR_RATE, 8'h00, rd, err);
      check("rate reg", rd, {24'h0, sh_rate});
      apb(1'b0, AGR_ADDR_VREF, 8'h00, rd, err);
      check("vref reg", rd, {24'h0, sh_vref});
      ec = exp_cfg(sh_gain, sh_rate, sh_vref);
      check("cfg", 32'(cfg), 32'(ec));
   endtask

   // restart with a given wait code and time the conv_start pulse
   task automatic timed(input logic [2:0] code);
      int cnt, n;
      n = wait_len(code) * AGR_MOD_CYC;
      wr(AGR_ADDR_GAIN, {code, 5'b01010});
      repeat (2) @(posedge clk);
      check("busy after restart", {31'h0, wait_busy}, 32'h1);
      cnt = 2;
      while (conv_start !== 1'b1 && cnt < n + 20) begin
         @(posedge clk);
         cnt++;
      end
      check("wait length ok", {31'h0, (cnt >= n - 3 && cnt <= n + 3)}, 32'h1);
      check("busy at start", {31'h0, wait_busy}, 32'h0);
      @(posedge clk);
      check("start pulse width", {31'h0, conv_start}, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0]  g, r, v;
      logic [31:0] rd;
      logic        err, seen_any;
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      n_errors = 0;
      comparisons = 0;
      sh_gain = 8'h00; sh_rate = 8'h14; sh_vref = 8'h10;
      void'($urandom(75));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      check_all();
      // every gain code with the amplifier on, then bypass at gain 1
      for (int i = 0; i < 8; i++) begin
         wr(AGR_ADDR_GAIN, {3'h0, 2'b01, 3'(i)});
         check_all();
      end
      wr(AGR_ADDR_GAIN, 8'h00);
      check_all();
      // reserved codes avoided
      // random legal settings; reserved codes stay out of the stimulus
      repeat (30) begin
         g[7:5] = 3'($urandom_range(0, 6));
         if (g[7:5] == 3'h6) g[7:5] = 3'h7;
         g[4:3] = 2'($urandom_range(0, 1));
         g[2:0] = (g[4:3] == 2'b01) ? 3'($urandom) : 3'h0;
         r = {4'($urandom), 4'($urandom_range(0, 11))};
         v = {2'($urandom), 1'b0, 1'($urandom), 2'($urandom_range(0, 2)),
              2'($urandom_range(0, 2))};
         wr(AGR_ADDR_GAIN, g);
         wr(AGR_ADDR_RATE, r);
         wr(AGR_ADDR_VREF, v);
         check_all();
      end
      // unmapped place: refused, nothing stored
      apb(1'b1, 8'h18, 8'hFF, rd, err);
      check("unmapped write err", {31'h0, err}, 32'h1);
      apb(1'b0, 8'h00, 8'h00, rd, err);
      check("unmapped read err", {31'h0, err}, 32'h1);
      check("unmapped read data", rd, 32'h0);
      check_all();
      // start wait for codes 7, 0, 1 and 2; each write differs from the one before
      wr(AGR_ADDR_GAIN, 8'h00);
      timed(3'h7);
      timed(3'h0);
      timed(3'h1);
      timed(3'h2);
      // rewriting the same value must not restart the wait
      wr(AGR_ADDR_GAIN, sh_gain);
      seen_any = 1'b0;
      repeat (80) begin
         @(posedge clk);
         seen_any = seen_any | wait_busy | conv_start;
      end
      check("no restart on same value", {31'h0, seen_any}, 32'h0);
      // status word: no reserved code was ever written and no wait runs
      apb(1'b0, AGR_ADDR_CTRL, 8'h00, rd, err);
      check("status word", rd, 32'h0);
      wr(AGR_ADDR_CTRL, 8'h01);
      close_out();
   end

   // watchdog, well beyond the longest run of the sequence
   initial begin
      #(30000 * 100);
      n_errors++;
      close_out();
   end
endmodule
